// File: design/dpc_counter.sv
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module dpc_counter
    import dpc_pkg::*;
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             ce,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic [DIN_W-1:0] din,
    output logic      [NCH-1:0]   flag_img,
    output logic      [NCH-1:0]   do_img
);

    typedef struct packed {
        dpc_mode_t               mode;
        logic                    ctrlin;
        logic [31:0]             setp;
        logic [CTL_W-1:0]        ctl;
        logic [NCH-1:0][CW-1:0]  cnt;
        logic [NCH-1:0]          flag;
        logic [NCH-1:0]          do_o;
        logic [NCH-1:0]          gate_p;
        logic [NCH-1:0]          rc_p;
        logic [NCH-1:0]          ro_p;
        logic [NCH-1:0]          pin_p;
        logic [31:0]             rdata;
    } dpc_state_t;

    dpc_state_t       st_r;
    dpc_state_t       st_nxt;
    logic [DIN_W-1:0] din_s;
    logic [NCH-1:0]   gate_l;
    logic [NCH-1:0]   rc_l;
    logic [NCH-1:0]   ro_l;
    logic [NCH-1:0]   gate_e;
    logic [NCH-1:0]   rc_e;
    logic [NCH-1:0]   ro_e;
    logic [NCH-1:0]   pin_e;
    logic [32:0]      stp;
    logic             wr_en;
    dpc_mode_t        new_mode;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic map_ok(input logic [7:0] a);
        map_ok = (a == OFF_CFG) || (a == OFF_SETP) || (a == OFF_CTL) ||
                 (a == OFF_STAT) || (a == OFF_CNT);
    endfunction

    // unknown mode code leaves the current arrangement in place
    function automatic dpc_mode_t dec_mode(input logic [1:0] code, input dpc_mode_t cur);
        unique case (code)
            MODE_CODE_UP:   dec_mode = DPC_UP;
            MODE_CODE_DOWN: dec_mode = DPC_DOWN;
            MODE_CODE_CASC: dec_mode = DPC_CASC;
            default:        dec_mode = cur;
        endcase
    endfunction

    // one down step: bit 32 marks reaching zero, in which case the
    // setpoint comes back as the new actual value
    function automatic logic [32:0] dn_step(input logic [31:0] c, input logic [31:0] sp, input logic [31:0] top);
        if (c <= 32'h0000_0001)
        begin
            dn_step = {1'b1, sp & top};
        end
        else
        begin
            dn_step = {1'b0, (c - 32'h0000_0001) & top};
        end
    endfunction

    // ----------------------------------------------------------------
    // input synchronisation
    // ----------------------------------------------------------------
    dpc_sync #(
        .W (DIN_W)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .d       (din),
        .q       (din_s)
    );

    // ----------------------------------------------------------------
    // control combining and edge detection
    // ----------------------------------------------------------------
    always_comb
    begin
        for (int c = 0; c < NCH; c++)
        begin
            gate_l[c] = st_r.ctl[CTL_GATE_LSB + c] | (st_r.ctrlin & din_s[PIN_GATE_LSB + c]);
            rc_l[c]   = st_r.ctl[CTL_RCNT_LSB + c] | (st_r.ctrlin & din_s[PIN_RCNT_LSB + c]);
            ro_l[c]   = st_r.ctl[CTL_ROUT_LSB + c] | (st_r.ctrlin & din_s[PIN_ROUT_LSB + c]);
        end
        gate_e = gate_l & ~st_r.gate_p;
        rc_e   = rc_l & ~st_r.rc_p;
        ro_e   = ro_l & ~st_r.ro_p;
        pin_e  = din_s[NCH-1:0] & ~st_r.pin_p;
    end

    assign wr_en    = psel && penable && pwrite && map_ok(paddr);
    assign new_mode = dec_mode(pwdata[CFG_MODE_LSB +: 2], st_r.mode);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        stp    = '0;
        // output clears are applied before sets so a same-cycle event is kept; a counter clear drops a same-cycle pulse
        for (int c = 0; c < NCH; c++)
        begin
            if (st_r.mode == DPC_UP)
            begin
                if (rc_e[c])
                begin
                    st_nxt.cnt[c]  = '0;
                    st_nxt.flag[c] = 1'b0;
                end
                else
                begin
                    if (ro_e[c])
                    begin
                        st_nxt.flag[c] = 1'b0;
                    end
                    if (pin_e[c] && !gate_l[c])
                    begin
                        st_nxt.cnt[c] = st_r.cnt[c] + 16'h0001;
                        if (st_r.cnt[c] == CNT_MAX)
                        begin
                            st_nxt.flag[c] = 1'b1;
                        end
                    end
                end
            end
            else if (st_r.mode == DPC_DOWN)
            begin
                if (rc_e[c])
                begin
                    st_nxt.cnt[c]  = st_r.setp[CW*c +: CW];
                    st_nxt.flag[c] = 1'b0;
                end
                else
                begin
                    if (ro_e[c] || gate_e[c])
                    begin
                        st_nxt.flag[c] = 1'b0;
                    end
                    if (pin_e[c] && !gate_l[c])
                    begin
                        stp = dn_step({16'h0000, st_r.cnt[c]}, {16'h0000, st_r.setp[CW*c +: CW]},
                                      32'h0000_FFFF);
                        st_nxt.cnt[c] = stp[CW-1:0];
                        if (stp[32])
                        begin
                            st_nxt.flag[c] = 1'b1;
                        end
                    end
                end
            end
        end
        // cascaded: channel one controls and pulses only; second pulse input idle
        if (st_r.mode == DPC_CASC)
        begin
            if (rc_e[0])
            begin
                {st_nxt.cnt[1], st_nxt.cnt[0]} = st_r.setp;
                st_nxt.flag[0] = 1'b0;
            end
            else
            begin
                if (ro_e[0] || gate_e[0])
                begin
                    st_nxt.flag[0] = 1'b0;
                end
                if (pin_e[0] && !gate_l[0])
                begin
                    stp = dn_step({st_r.cnt[1], st_r.cnt[0]}, st_r.setp, 32'hFFFF_FFFF);
                    {st_nxt.cnt[1], st_nxt.cnt[0]} = stp[31:0];
                    if (stp[32])
                    begin
                        st_nxt.flag[0] = 1'b1;
                    end
                end
            end
            st_nxt.flag[1] = 1'b0;
        end
        // register writes; switching arrangement restarts from zero
        if (wr_en)
        begin
            unique case (paddr)
                OFF_CFG:
                begin
                    st_nxt.mode   = new_mode;
                    st_nxt.ctrlin = pwdata[CFG_CTRLIN_BIT];
                    if (new_mode != st_r.mode)
                    begin
                        st_nxt.cnt  = '0;
                        st_nxt.flag = '0;
                    end
                end
                OFF_SETP: st_nxt.setp = pwdata;
                OFF_CTL:  st_nxt.ctl  = pwdata[CTL_W-1:0];
                default:  st_nxt.setp = st_r.setp;
            endcase
        end
        // read data is captured in the setup phase so the access phase needs no wait
        if (psel && !penable)
        begin
            unique case (paddr)
                OFF_CFG:  st_nxt.rdata = {29'h0, st_r.ctrlin,
                                          (st_r.mode == DPC_CASC) ? MODE_CODE_CASC :
                                          (st_r.mode == DPC_DOWN) ? MODE_CODE_DOWN : MODE_CODE_UP};
                OFF_SETP: st_nxt.rdata = st_r.setp;
                OFF_CTL:  st_nxt.rdata = {26'h0, st_r.ctl};
                OFF_STAT: st_nxt.rdata = {30'h0, st_r.flag};
                OFF_CNT:  st_nxt.rdata = {st_r.cnt[1], st_r.cnt[0]};
                default:  st_nxt.rdata = 32'h0000_0000;
            endcase
        end
        st_nxt.do_o   = (st_nxt.mode == DPC_UP) ? 2'h0 : st_nxt.flag;
        st_nxt.gate_p = gate_l;
        st_nxt.rc_p   = rc_l;
        st_nxt.ro_p   = ro_l;
        st_nxt.pin_p  = din_s[NCH-1:0];
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r      <= '0;
            st_r.mode <= DPC_UP;
            st_r.setp <= SETP_RST;
            st_r.ctl  <= CTL_RST;
        end
        else if (ce)
        begin
            st_r <= st_nxt;
        end
    end

    assign prdata   = st_r.rdata;
    assign pready   = ce;
    assign pslverr  = psel && penable && !map_ok(paddr);
    assign flag_img = st_r.flag;
    assign do_img   = st_r.do_o;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    up_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && st_r.mode == DPC_UP && pin_e[0] && !gate_l[0] && !rc_e[0] && !wr_en && st_r.cnt[0] == CNT_MAX
        |=> st_r.cnt[0] == 16'h0000 && st_r.flag[0])
        else $error("up counter did not wrap with flag");

    up_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && st_r.mode == DPC_UP && pin_e[1] && !gate_l[1] && !rc_e[1] && !wr_en
        |=> st_r.cnt[1] == $past(st_r.cnt[1]) + 16'h0001)
        else $error("up counter did not add one");

    up_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && st_r.mode == DPC_UP && rc_e[0] && !wr_en |=> st_r.cnt[0] == 16'h0000 && !st_r.flag[0])
        else $error("counter clear did not zero count and flag");

    up_outs_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_r.mode == DPC_UP |-> do_img == 2'h0)
        else $error("output image bits set in up mode");

    gate_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && gate_l[0] && !rc_e[0] && !wr_en ##1 ce && gate_l[0] && !rc_e[0] && !wr_en
        |=> $stable(st_r.cnt[0]))
        else $error("count moved while gated");

    dn_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && st_r.mode == DPC_DOWN && pin_e[0] && !gate_l[0] && !rc_e[0] && !wr_en && st_r.cnt[0] == 16'h0001
        |=> st_r.flag[0] && st_r.cnt[0] == $past(st_r.setp[15:0]))
        else $error("down counter did not reload at zero");

    dn_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && st_r.mode == DPC_DOWN && pin_e[0] && !gate_l[0] && !rc_e[0] && !wr_en && st_r.cnt[0] > 16'h0001
        |=> st_r.cnt[0] == $past(st_r.cnt[0]) - 16'h0001)
        else $error("down counter did not subtract one");

    casc_ch2_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && st_r.mode == DPC_CASC && !wr_en |=> !st_r.flag[1] && !do_img[1])
        else $error("second channel active in cascaded mode");

    dn_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && st_r.mode == DPC_DOWN && gate_e[1] && !wr_en |=> !st_r.flag[1])
        else $error("gate edge did not clear down flag");

    out_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && ro_e[0] && !pin_e[0] && !rc_e[0] && !wr_en && st_r.mode != DPC_CASC
        |=> !st_r.flag[0] && $stable(st_r.cnt[0]))
        else $error("output clear misbehaved");

    dn_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && st_r.mode == DPC_CASC && rc_e[0] && !wr_en
        |=> {st_r.cnt[1], st_r.cnt[0]} == $past(st_r.setp) && !st_r.flag[0] ##1 !st_r.flag[1])
        else $error("cascaded clear did not load setpoint");

endmodule
`default_nettype wire

// File: design/dpc_pkg.sv
package dpc_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses, one 32-bit word each)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_CFG  = 8'h00;
    localparam logic [7:0] OFF_SETP = 8'h04;
    localparam logic [7:0] OFF_CTL  = 8'h08;
    localparam logic [7:0] OFF_STAT = 8'h0C;
    localparam logic [7:0] OFF_CNT  = 8'h10;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int CFG_MODE_LSB   = 0;
    localparam int CFG_CTRLIN_BIT = 2;
    localparam int CTL_GATE_LSB   = 0;
    localparam int CTL_RCNT_LSB   = 2;
    localparam int CTL_ROUT_LSB   = 4;
    localparam int CTL_W          = 6;

    localparam logic [1:0]  MODE_CODE_UP   = 2'h0;
    localparam logic [1:0]  MODE_CODE_DOWN = 2'h1;
    localparam logic [1:0]  MODE_CODE_CASC = 2'h2;
    localparam logic [31:0] SETP_RST       = 32'h0000_0000;
    localparam logic [5:0]  CTL_RST        = 6'h00;
    localparam logic [15:0] CNT_MAX        = 16'hFFFF;

    // ----------------------------------------------------------------
    // pin mapping of the control-input configuration
    // ----------------------------------------------------------------
    localparam int NCH          = 2;
    localparam int DIN_W        = 8;
    localparam int CW           = 16;
    localparam int PIN_GATE_LSB = 2;
    localparam int PIN_RCNT_LSB = 4;
    localparam int PIN_ROUT_LSB = 6;

    typedef enum logic [2:0] {
        DPC_UP   = 3'b001,
        DPC_DOWN = 3'b010,
        DPC_CASC = 3'b100
    } dpc_mode_t;

endpackage

// File: design/dpc_sync.sv
`timescale 1ns/10ps
`default_nettype none

module dpc_sync
    import dpc_pkg::*;
#(
    parameter int W = 8
)
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } dpc_sync_t;

    dpc_sync_t st_r;
    dpc_sync_t st_nxt;

    // a level change is accepted only once stages two and three agree
    always_comb
    begin
        st_nxt    = st_r;
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < W; i++)
        begin
            if (st_r.s2[i] == st_r.s3[i])
            begin
                st_nxt.q[i] = st_r.s3[i];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= '0;
        end
        else if (ce)
        begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.q;

endmodule
`default_nettype wire

// File: testbench/dpc_sensor.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// pulse sensors and control contacts on the eight input pins
// ----------------------------------------------------------------
module dpc_sensor
    import dpc_pkg::*;
(
    input  wire logic             pclk,
    output var  logic [DIN_W-1:0] din
);
    initial din = 8'h00;

    // four cycles high and four low, well above the two the synchroniser needs
    task pulse(input int ch, input int n);
        repeat (n)
        begin
            @(posedge pclk);
            din[ch] <= 1'b1;
            repeat (4) @(posedge pclk);
            din[ch] <= 1'b0;
            repeat (4) @(posedge pclk);
        end
    endtask

    // contacts are plain levels; the block uses the edges of the clear contacts and the level of the gate contact
    task level(input int idx, input logic v);
        @(posedge pclk);
        din[idx] <= v;
    endtask
endmodule

`default_nettype wire

// File: testbench/test_dual_pulse_counter.sv
`timescale 1ns/10ps
`default_nettype none

module test_dual_pulse_counter
    import dpc_pkg::*;
;
    logic             pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0]       paddr;
    logic [31:0]      pwdata, prdata, rd;
    logic [DIN_W-1:0] din;
    logic [NCH-1:0]   flag_img, do_img;
    int               n_errors, n_tests;

    dpc_counter dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .din(din), .flag_img(flag_img), .do_img(do_img));
    dpc_sensor sensor (.pclk(pclk), .din(din));

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ----------------------------------------------------------------
    // bus and checking helpers
    // ----------------------------------------------------------------
    task results;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp)
        begin
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
            n_errors++;
        end
    endtask

    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        i = 0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            i++;
        end
        while (pready !== 1'b1 && i < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i >= 50)
        begin
            $display("[FAIL] %0t bus wait timed out", $time);
            n_errors++;
            results;
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] e, input string m);
        xfer(1'b0, a, 32'h0000_0000);
        chk(rd, e, m);
    endtask

    task idle;
        repeat (10) @(posedge pclk);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_reset;
        rdc(OFF_CFG, 32'h0000_0000, "cfg reset");
        chk({31'h0, er}, 32'h0000_0000, "mapped no error");
        rdc(OFF_SETP, 32'h0000_0000, "setp reset");
        rdc(OFF_CTL, 32'h0000_0000, "ctl reset");
        wr(OFF_STAT, 32'hFFFF_FFFF);
        rdc(OFF_STAT, 32'h0000_0000, "stat read only");
        rdc(8'h14, 32'h0000_0000, "unmapped read");
        chk({31'h0, er}, 32'h0000_0001, "unmapped error");
        wr(8'h14, 32'hFFFF_FFFF);
        chk({31'h0, er}, 32'h0000_0001, "unmapped write error");
        wr(OFF_CFG, 32'h0000_0003);
        rdc(OFF_CFG, 32'h0000_0000, "mode code three ignored");
        chk({28'h0, flag_img, do_img}, 32'h0000_0000, "images at reset");
        $display("test reset done");
    endtask

    task t_up;
        sensor.pulse(0, 3);
        sensor.pulse(1, 5);
        idle;
        rdc(OFF_CNT, 32'h0005_0003, "up count");
        chk({30'h0, do_img}, 32'h0000_0000, "up outputs");
        // a pulse that comes and goes while the enable is low must leave no trace
        @(posedge pclk);
        ce <= 1'b0;
        sensor.pulse(0, 2);
        chk({31'h0, pready}, 32'h0000_0000, "ready low when frozen");
        ce <= 1'b1;
        idle;
        rdc(OFF_CNT, 32'h0005_0003, "frozen while disabled");
        wr(OFF_CTL, 32'h0000_0004);
        idle;
        rdc(OFF_CNT, 32'h0005_0000, "up clear");
        wr(OFF_CTL, 32'h0000_0000);
        $display("test up done");
    endtask

    task t_gate;
        sensor.pulse(0, 2);
        wr(OFF_CTL, 32'h0000_0001);
        idle;
        sensor.pulse(0, 2);
        idle;
        rdc(OFF_CNT, 32'h0005_0002, "gated pulses");
        wr(OFF_CTL, 32'h0000_0005);
        idle;
        rdc(OFF_CNT, 32'h0005_0000, "clear under gate");
        wr(OFF_CTL, 32'h0000_0000);
        idle;
        sensor.pulse(0, 1);
        idle;
        rdc(OFF_CNT, 32'h0005_0001, "count after gate");
        $display("test gate done");
    endtask

    task t_down;
        wr(OFF_CFG, {30'h0, MODE_CODE_DOWN});
        wr(OFF_SETP, 32'h0005_0002);
        wr(OFF_CTL, 32'h0000_000C);
        idle;
        wr(OFF_CTL, 32'h0000_0000);
        idle;
        rdc(OFF_CNT, 32'h0005_0002, "down start");
        sensor.pulse(0, 1);
        idle;
        rdc(OFF_CNT, 32'h0005_0001, "down step");
        wr(OFF_SETP, 32'h0005_0007);
        idle;
        rdc(OFF_CNT, 32'h0005_0001, "setp not adopted");
        sensor.pulse(0, 1);
        idle;
        rdc(OFF_CNT, 32'h0005_0007, "reload at zero");
        chk({28'h0, flag_img, do_img}, 32'h0000_0005, "flag at zero");
        wr(OFF_CTL, 32'h0000_0010);
        idle;
        rdc(OFF_STAT, 32'h0000_0000, "output clear");
        rdc(OFF_CNT, 32'h0005_0007, "count kept");
        sensor.pulse(0, 7);
        idle;
        chk({30'h0, flag_img}, 32'h0000_0001, "flag again");
        wr(OFF_CTL, 32'h0000_0011);
        idle;
        chk({30'h0, flag_img}, 32'h0000_0000, "gate clears flag");
        wr(OFF_CTL, 32'h0000_0000);
        $display("test down done");
    endtask

    task t_casc;
        wr(OFF_CFG, {30'h0, MODE_CODE_CASC});
        wr(OFF_SETP, 32'h0001_0001);
        wr(OFF_CTL, 32'h0000_0004);
        idle;
        wr(OFF_CTL, 32'h0000_0000);
        idle;
        rdc(OFF_CNT, 32'h0001_0001, "casc start");
        sensor.pulse(1, 2);
        idle;
        rdc(OFF_CNT, 32'h0001_0001, "second input idle");
        sensor.pulse(0, 2);
        idle;
        rdc(OFF_CNT, 32'h0000_FFFF, "borrow across halves");
        chk({30'h0, flag_img}, 32'h0000_0000, "casc flags");
        $display("test cascade done");
    endtask

    task t_pins;
        wr(OFF_CFG, 32'h0000_0004);
        sensor.pulse(0, 2);
        sensor.level(PIN_GATE_LSB, 1'b1);
        idle;
        sensor.pulse(0, 2);
        idle;
        rdc(OFF_CNT, 32'h0000_0002, "pin gate");
        sensor.level(PIN_RCNT_LSB, 1'b1);
        idle;
        rdc(OFF_CNT, 32'h0000_0000, "pin clear");
        sensor.level(PIN_RCNT_LSB, 1'b0);
        sensor.level(PIN_GATE_LSB, 1'b0);
        idle;
        sensor.pulse(0, 1);
        idle;
        rdc(OFF_CNT, 32'h0000_0001, "pin gate released");
        sensor.pulse(1, 2);
        sensor.level(PIN_GATE_LSB + 1, 1'b1);
        idle;
        sensor.pulse(1, 1);
        idle;
        rdc(OFF_CNT, 32'h0002_0001, "pin gate two");
        sensor.level(PIN_RCNT_LSB + 1, 1'b1);
        idle;
        rdc(OFF_CNT, 32'h0000_0001, "pin clear two");
        sensor.level(PIN_RCNT_LSB + 1, 1'b0);
        sensor.level(PIN_GATE_LSB + 1, 1'b0);
        wr(OFF_CFG, 32'h0000_0005);
        sensor.pulse(0, 1);
        idle;
        chk({30'h0, flag_img}, 32'h0000_0001, "pin down flag");
        sensor.level(PIN_ROUT_LSB, 1'b1);
        idle;
        chk({30'h0, flag_img}, 32'h0000_0000, "pin output clear");
        $display("test pins done");
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        n_errors = 0;
        n_tests = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_up;
        t_gate;
        t_down;
        t_casc;
        t_pins;
        results;
    end
endmodule

`default_nettype wire
